//--- hw/host_pin_params.svh
// Constants for the host pin configuration unit.
// Assumes inclusion by bare name from the hw/ directory.
//
// Notes on behaviour
// - Selector port field is bits 6..4; only port zero exists, others reserved.
// - Selector pin field is bits 2..0, choosing pin zero through seven.
// - Index f1 reaches the per-pin register of the currently selected pin.
// - Config bit 6 enables event debounce; resets to enabled.
// - Config bit 5 is event polarity; zero is falling or low.
// - Config bit 4 is event kind; zero is edge, one is level.
// - Load bit 4 forces buffers and pull-up off while main supply is low.
// - Load flag zero: standby reset clears pin; one: main reset, flag kept.
// - Standard registers reset by main reset; f0 sits in standby domain.
// - Pin registers follow their load flag's reset domain, except the lock.
// - Activate clear blocks access but keeps contents and event detection.
// - Base low byte bits 2..0 read as zero.
// - Interrupt type: only bit 1 writable; resets to 03.
// - Indexes 74 and 75 read only and return 04.
`ifndef HOST_PIN_PARAMS_SVH
`define HOST_PIN_PARAMS_SVH

`define IDX_ACTIVATE 8'h30
`define IDX_BASE_HIGH 8'h60
`define IDX_BASE_LOW 8'h61
`define IDX_IRQ_NUM 8'h70
`define IDX_IRQ_TYPE 8'h71
`define IDX_DMA_A 8'h74
`define IDX_DMA_B 8'h75
`define IDX_PIN_SEL 8'hf0
`define IDX_PIN_CFG 8'hf1
`define IDX_PIN_EVR 8'hf2
`define IDX_PIN_LOAD 8'hf3

`define RST_IRQ_TYPE 8'h03
`define VAL_NO_DMA 8'h04
`define RST_PIN_CFG 8'h44
`define MASK_BASE_LOW 8'hf8
`define MASK_IRQ_TYPE_WR 8'h02
`define MASK_PIN_SEL 8'h77
`define MASK_CFG_LOCKED 8'h70
`define MASK_CFG_FREE 8'h77
`define MASK_EVR 8'h03
`define MASK_LOAD 8'h10

`define BIT_ACTIVE 0
`define BIT_DEBOUNCE 6
`define BIT_POLARITY 5
`define BIT_KIND 4
`define BIT_LOCK 3
`define BIT_PULLUP 2
`define BIT_DRV_KIND 1
`define BIT_DRV_ON 0
`define BIT_MGMT 1
`define BIT_HOST 0
`define BIT_LOAD 4
`define PORT_LSB 4
`define PORT_MSB 6
`define PIN_MSB 2

`define DEBOUNCE_NS 1000
`define CLK_NS 40
`define DEBOUNCE_CYCLES ((`DEBOUNCE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

//--- hw/host_pin_pkg.sv
// Types for the host pin configuration unit.
// Assumes nothing beyond a SystemVerilog compiler.
package host_pin_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        ev_idle = 2'b00,
        ev_wait = 2'b01,
        ev_held = 2'b10
    } deb_state_t;
endpackage : host_pin_pkg

//--- hw/pin_event_filter.sv
// Per-pin event recogniser with optional debounce.
// Assumes pin input already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
`include "host_pin_params.svh"
module pin_event_filter #(
    parameter int DEB_CYCLES = `DEBOUNCE_CYCLES
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pin and settings
    input wire logic pin_in,
    input wire logic debounce_on,
    input wire logic polarity,
    input wire logic level_kind,
    // Result
    output logic event_pulse
);
    localparam int CW = $clog2(DEB_CYCLES + 1);
    host_pin_pkg::deb_state_t state;
    logic [CW-1:0] count;
    logic stable;
    logic stable_q;
    logic active;

    // Debounce: level must hold for the full period
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= host_pin_pkg::ev_idle;
            count <= '0;
            stable <= 1'b0;
        end
        else if (!debounce_on)
        begin
            state <= host_pin_pkg::ev_idle;
            stable <= pin_in;
            count <= '0;
        end
        else
        begin
            case (state)
                host_pin_pkg::ev_idle:
                begin
                    if (pin_in != stable)
                    begin
                        state <= host_pin_pkg::ev_wait;
                        count <= '0;
                    end
                end
                host_pin_pkg::ev_wait:
                begin
                    if (pin_in == stable)
                        state <= host_pin_pkg::ev_idle;
                    else if (count == CW'(DEB_CYCLES - 1))
                        state <= host_pin_pkg::ev_held;
                    else
                        count <= count + 1'b1;
                end
                host_pin_pkg::ev_held:
                begin
                    stable <= pin_in;
                    state <= host_pin_pkg::ev_idle;
                end
                default:
                    state <= host_pin_pkg::ev_idle;
            endcase
        end
    end

    // Polarity and edge or level detection
    assign active = polarity ? stable : ~stable;
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            stable_q <= 1'b1; // No false edge on the first cycle after reset
            event_pulse <= 1'b0;
        end
        else
        begin
            stable_q <= active;
            event_pulse <= level_kind ? active : (active & ~stable_q);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst_b && state == host_pin_pkg::ev_held)
        begin
            deb_len_a: assert (count == CW'(DEB_CYCLES - 1))
            else $error("debounce ended before the full period");
        end
    end
endmodule : pin_event_filter
`default_nettype wire

//--- hw/pin_bank_regs.sv
// Configuration storage for all pins of the bank.
// Assumes the caller has decoded the index and selected pin.
`timescale 1ns/1ps
`default_nettype none
`include "host_pin_params.svh"
module pin_bank_regs #(
    parameter int PINS = 8
)(
    // Clock and resets
    input wire logic clk,
    input wire logic rst_b,
    input wire logic standby_rst,
    input wire logic main_rst,
    // Write port
    input wire logic [$clog2(PINS)-1:0] sel,
    input wire logic wr_cfg,
    input wire logic wr_evr,
    input wire logic wr_load,
    input wire logic [7:0] wdata,
    // Stored values
    output logic [7:0] cfg [PINS],
    output logic [7:0] evr [PINS],
    output logic [PINS-1:0] load
);
    logic [PINS-1:0] lock_q;

    // Storage per pin, reset domain chosen by its load flag
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < PINS; i++)
        begin
            if (!rst_b)
            begin
                cfg[i] <= `RST_PIN_CFG;
                evr[i] <= 8'h00;
                load[i] <= 1'b0;
            end
            else if (load[i] ? main_rst : standby_rst)
            begin
                cfg[i] <= `RST_PIN_CFG & ~(8'h01 << `BIT_LOCK) | (cfg[i] & (8'h01 << `BIT_LOCK));
                evr[i] <= 8'h00;
                if (!load[i])
                    load[i] <= 1'b0;
            end
            else if (sel == ($clog2(PINS))'(i))
            begin
                if (wr_cfg)
                begin
                    if (cfg[i][`BIT_LOCK])
                        cfg[i] <= (cfg[i] & ~`MASK_CFG_LOCKED) | (wdata & `MASK_CFG_LOCKED);
                    else
                        cfg[i] <= (wdata & `MASK_CFG_FREE) | (wdata & (8'h01 << `BIT_LOCK));
                end
                if (wr_evr && !cfg[i][`BIT_LOCK])
                    evr[i] <= wdata & `MASK_EVR;
                if (wr_load)
                    load[i] <= wdata[`BIT_LOAD];
            end
        end
    end

    // Lock history; a set lock may only fall with rst_b
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < PINS; i++)
        begin
            if (!rst_b)
                lock_q[i] <= 1'b0;
            else
                lock_q[i] <= cfg[i][`BIT_LOCK];
            if (rst_b && lock_q[i])
            begin
                lock_hold_a: assert (cfg[i][`BIT_LOCK])
                else $error("lock dropped");
            end
        end
    end
endmodule : pin_bank_regs
`default_nettype wire

//--- hw/host_pin_unit.sv
// Top of the host pin configuration unit: index/data config access.
// Assumes host bus already decoded index, write strobe and read data path.
`timescale 1ns/1ps
`default_nettype none
`include "host_pin_params.svh"
module host_pin_unit #(
    parameter int PINS = 8,
    parameter int DEB_CYCLES = `DEBOUNCE_CYCLES
)(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Reset domains
    input wire logic standby_rst,
    input wire logic main_rst,
    input wire logic main_supply_low,
    // Configuration access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_index,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Pins
    input wire logic [PINS-1:0] pin_in,
    input wire logic [PINS-1:0] data_out_req,
    input wire logic [PINS-1:0] data_out_wr,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pullup_on,
    output logic [PINS-1:0] input_on,
    // Events
    output logic [PINS-1:0] mgmt_event,
    output logic [PINS-1:0] host_event
);
    localparam int SW = $clog2(PINS);
    logic [7:0] unit_activate;
    logic [7:0] base_address_high;
    logic [7:0] base_address_low;
    logic [7:0] irq_number_wake;
    logic [7:0] irq_type;
    logic [7:0] pin_selector;
    logic [7:0] cfg [PINS];
    logic [7:0] evr [PINS];
    logic [PINS-1:0] load;
    logic [PINS-1:0] pin_s1;
    logic [PINS-1:0] pin_s2;
    logic [PINS-1:0] events;
    logic [PINS-1:0] pin_data_out;
    logic [PINS-1:0] off;
    logic [SW-1:0] pin_choice;
    logic [2:0] port_choice;
    logic access_ok;
    logic port_ok;
    logic low_s1;
    logic low_s2;
    logic [7:0] next_rdata;

    // Field decode of the selector
    assign pin_choice = pin_selector[SW-1:0];
    assign port_choice = pin_selector[`PORT_MSB:`PORT_LSB];
    assign port_ok = (port_choice == 3'h0);
    assign access_ok = unit_activate[`BIT_ACTIVE];

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction : hit

    // Pin and supply synchronisers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            low_s1 <= 1'b0;
            low_s2 <= 1'b0;
        end
        else
        begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            low_s1 <= main_supply_low;
            low_s2 <= low_s1;
        end
    end

    // Standard registers in the main domain
    always_ff @(posedge clk)
    begin
        if (!rst_b || main_rst)
        begin
            unit_activate <= 8'h00;
            base_address_high <= 8'h00;
            base_address_low <= 8'h00;
            irq_number_wake <= 8'h00;
            irq_type <= `RST_IRQ_TYPE;
        end
        else if (cfg_wr)
        begin
            if (hit(cfg_index, `IDX_ACTIVATE))
                unit_activate <= cfg_wdata;
            if (access_ok && hit(cfg_index, `IDX_BASE_HIGH))
                base_address_high <= cfg_wdata;
            if (access_ok && hit(cfg_index, `IDX_BASE_LOW))
                base_address_low <= cfg_wdata & `MASK_BASE_LOW;
            if (access_ok && hit(cfg_index, `IDX_IRQ_NUM))
                irq_number_wake <= cfg_wdata;
            if (access_ok && hit(cfg_index, `IDX_IRQ_TYPE))
                irq_type <= (irq_type & ~`MASK_IRQ_TYPE_WR) | (cfg_wdata & `MASK_IRQ_TYPE_WR);
        end
    end

    // Pin selector in the standby domain
    always_ff @(posedge clk)
    begin
        if (!rst_b || standby_rst)
            pin_selector <= 8'h00;
        else if (cfg_wr && access_ok && hit(cfg_index, `IDX_PIN_SEL))
            pin_selector <= cfg_wdata & `MASK_PIN_SEL;
    end

    pin_bank_regs #(
        .PINS(PINS)
    ) bank (
        .clk(clk),
        .rst_b(rst_b),
        .standby_rst(standby_rst),
        .main_rst(main_rst),
        .sel(pin_choice),
        .wr_cfg(cfg_wr && access_ok && port_ok && hit(cfg_index, `IDX_PIN_CFG)),
        .wr_evr(cfg_wr && access_ok && port_ok && hit(cfg_index, `IDX_PIN_EVR)),
        .wr_load(cfg_wr && access_ok && port_ok && hit(cfg_index, `IDX_PIN_LOAD)),
        .wdata(cfg_wdata),
        .cfg(cfg),
        .evr(evr),
        .load(load)
    );

    // Event recognisers, running regardless of activate
    for (genvar g = 0; g < PINS; g++)
    begin : gen_ev
        pin_event_filter #(
            .DEB_CYCLES(DEB_CYCLES)
        ) filt (
            .clk(clk),
            .rst_b(rst_b),
            .pin_in(pin_s2[g]),
            .debounce_on(cfg[g][`BIT_DEBOUNCE]),
            .polarity(cfg[g][`BIT_POLARITY]),
            .level_kind(cfg[g][`BIT_KIND]),
            .event_pulse(events[g])
        );
    end

    // Data-out bits, guarded by lock and reset by the pin's domain
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < PINS; i++)
        begin
            if (!rst_b || (load[i] ? main_rst : standby_rst))
                pin_data_out[i] <= 1'b0;
            else if (data_out_wr[i] && !cfg[i][`BIT_LOCK])
                pin_data_out[i] <= data_out_req[i];
        end
    end

    // Pin drive, routing and supply-loss gating
    always_comb
    begin
        for (int i = 0; i < PINS; i++)
            off[i] = load[i] & low_s2;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            pin_out <= '0;
            pin_oe <= '0;
            pullup_on <= '0;
            input_on <= '0;
            mgmt_event <= '0;
            host_event <= '0;
        end
        else
        begin
            for (int i = 0; i < PINS; i++)
            begin
                pin_out[i] <= pin_data_out[i];
                pin_oe[i] <= cfg[i][`BIT_DRV_ON] & ~off[i];
                pullup_on[i] <= cfg[i][`BIT_PULLUP] & ~off[i];
                input_on[i] <= ~off[i];
                mgmt_event[i] <= events[i] & evr[i][`BIT_MGMT];
                host_event[i] <= events[i] & evr[i][`BIT_HOST];
            end
        end
    end

    // Read multiplexer
    always_comb
    begin
        next_rdata = 8'h00;
        if (hit(cfg_index, `IDX_ACTIVATE))
            next_rdata = unit_activate;
        else if (access_ok)
        begin
            case (cfg_index)
                `IDX_BASE_HIGH: next_rdata = base_address_high;
                `IDX_BASE_LOW: next_rdata = base_address_low & `MASK_BASE_LOW;
                `IDX_IRQ_NUM: next_rdata = irq_number_wake;
                `IDX_IRQ_TYPE: next_rdata = irq_type;
                `IDX_DMA_A: next_rdata = `VAL_NO_DMA;
                `IDX_DMA_B: next_rdata = `VAL_NO_DMA;
                `IDX_PIN_SEL: next_rdata = pin_selector;
                `IDX_PIN_CFG: next_rdata = port_ok ? cfg[pin_choice] : 8'h00;
                `IDX_PIN_EVR: next_rdata = port_ok ? evr[pin_choice] : 8'h00;
                `IDX_PIN_LOAD: next_rdata = (port_ok && load[pin_choice]) ? `MASK_LOAD : 8'h00;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            cfg_rdata <= 8'h00;
        else if (cfg_rd)
            cfg_rdata <= next_rdata;
    end

    // Checks
    always_ff @(posedge clk)
    begin
        if (rst_b && !main_rst)
        begin
            base_low_a: assert (base_address_low[2:0] == 3'h0)
            else $error("base low bits not zero");
            irq_type_a: assert (irq_type[7:2] == 6'h00 && irq_type[0])
            else $error("read-only interrupt type bits changed");
        end
    end

    property no_dma_p;
        @(posedge clk) disable iff (!rst_b)
        (cfg_rd && access_ok && (cfg_index == `IDX_DMA_A || cfg_index == `IDX_DMA_B)) |=> (cfg_rdata == `VAL_NO_DMA);
    endproperty
    no_dma_a: assert property (no_dma_p)
    else $error("dma report not 04");

    sel_read_a: assert property (@(posedge clk) disable iff (!rst_b)
        (cfg_rd && access_ok && port_ok && cfg_index == `IDX_PIN_CFG) |=> (cfg_rdata == $past(cfg[pin_choice])))
    else $error("config read not of selected pin");

    // Every loaded pin, not just one
    supply_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        (off != '0 && !main_rst && !standby_rst) |=> (((pin_oe | pullup_on | input_on) & $past(off)) == '0))
    else $error("buffers on during supply loss");

    inactive_wr_a: assert property (@(posedge clk) disable iff (!rst_b || main_rst || standby_rst)
        (cfg_wr && !access_ok && cfg_index == `IDX_PIN_SEL) |=> $stable(pin_selector))
    else $error("write accepted while inactive");

    sel_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
        (pin_selector[7] == 1'b0 && pin_selector[3] == 1'b0))
    else $error("selector reserved bit set");

    // Locked fields of every pin hold across host writes
    for (genvar g = 0; g < PINS; g++)
    begin : gen_lock_chk
        lock_route_a: assert property (@(posedge clk) disable iff (!rst_b || main_rst || standby_rst)
            (cfg[g][`BIT_LOCK] && cfg_wr) |=> $stable(evr[g]) && $stable(cfg[g][3:0]))
        else $error("locked field changed");
    end
endmodule : host_pin_unit
`default_nettype wire

//--- sim/host_cfg_model.sv
// Host model: byte reads and writes through the config index/data pair.
// Assumes the unit samples strobes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_cfg_model (
    // Clock
    input wire logic clk,
    // Config access
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [7:0] cfg_index,
    output logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata
);
    // Idle bus at time zero
    initial
    begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_index = 8'h00;
        cfg_wdata = 8'h00;
    end

    // One write strobe; released lines show the inverse, not stale data
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_index <= idx;
        cfg_wdata <= val;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_index <= ~idx;
        cfg_wdata <= ~val;
    endtask : wr_reg

    // One read strobe; data is held until the next read
    task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_index <= idx;
        @(posedge clk);
        cfg_rd <= 1'b0;
        cfg_index <= ~idx;
        @(posedge clk);
        #1;
        val = cfg_rdata;
    endtask : rd_reg
endmodule : host_cfg_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the host pin configuration unit.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic standby_rst = 1'b0;
    logic main_rst = 1'b0;
    logic main_supply_low = 1'b0;
    logic cfg_wr, cfg_rd;
    logic [7:0] cfg_index, cfg_wdata, cfg_rdata;
    logic [7:0] pin_in = 8'h00;
    logic [7:0] data_out_req = 8'h00;
    logic [7:0] data_out_wr = 8'h00;
    logic [7:0] pin_out, pin_oe, pullup_on, input_on, mgmt_event, host_event;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    host_pin_pkg::byte_t rd, v, n, m;
    host_pin_pkg::byte_t cfg_exp [8];
    host_pin_pkg::byte_t evr_exp [8];

    // 25 MHz clock
    always #20 clk = ~clk;

    host_pin_unit #(.PINS(8), .DEB_CYCLES(2)) dut (
        .clk(clk), .rst_b(rst_b), .standby_rst(standby_rst), .main_rst(main_rst),
        .main_supply_low(main_supply_low), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_index(cfg_index), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .pin_in(pin_in), .data_out_req(data_out_req), .data_out_wr(data_out_wr),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on), .input_on(input_on),
        .mgmt_event(mgmt_event), .host_event(host_event)
    );

    host_cfg_model host (
        .clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_index(cfg_index),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata)
    );

    // Config readback after a write, honouring the lock
    function automatic host_pin_pkg::byte_t cfg_after(input host_pin_pkg::byte_t old, input host_pin_pkg::byte_t wr);
        cfg_after = old[3] ? ((old & 8'h0f) | (wr & 8'h70)) : (wr & 8'h7f);
    endfunction : cfg_after

    task automatic chk(input string what, input host_pin_pkg::byte_t exp, input host_pin_pkg::byte_t got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] idx, input host_pin_pkg::byte_t exp, input string what);
        host.rd_reg(idx, rd);
        chk(what, exp, rd);
    endtask : rd_chk

    // One-cycle data-out write to the pins in mask
    task automatic data_wr(input logic [7:0] mask, input logic [7:0] val);
        @(posedge clk);
        data_out_req <= val;
        data_out_wr <= mask;
        @(posedge clk);
        data_out_wr <= 8'h00;
        repeat (2) @(posedge clk);
    endtask : data_wr

    // One-cycle pulse on a domain reset
    task automatic pulse_rst(input bit main);
        @(posedge clk);
        if (main)
            main_rst <= 1'b1;
        else
            standby_rst <= 1'b1;
        @(posedge clk);
        main_rst <= 1'b0;
        standby_rst <= 1'b0;
    endtask : pulse_rst

    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            fails = fails + 1;
            summarize();
        end
    end

    // Main sequence
    initial
    begin
        v = 8'($urandom(32'h3052));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // Inactive unit refuses, then defaults after activation
        rd_chk(8'h71, 8'h00, "inactive type");
        host.wr_reg(8'h71, 8'h00);
        host.wr_reg(8'h30, 8'h01);
        rd_chk(8'h30, 8'h01, "activate");
        rd_chk(8'h71, 8'h03, "type reset");
        rd_chk(8'h74, 8'h04, "dma a");
        rd_chk(8'h75, 8'h04, "dma b");
        rd_chk(8'hf1, 8'h44, "cfg reset");
        rd_chk(8'hf2, 8'h00, "routing reset");
        // Read-only and masked bits under random writes
        repeat (4)
        begin
            v = 8'($urandom);
            host.wr_reg(8'h61, v);
            rd_chk(8'h61, v & 8'hf8, "base low");
            host.wr_reg(8'h71, v);
            rd_chk(8'h71, 8'h01 | (v & 8'h02), "irq type");
            host.wr_reg(8'h75, v);
            rd_chk(8'h75, 8'h04, "dma write");
        end
        // Random per-pin settings, lock kept clear
        for (int p = 0; p < 8; p++)
        begin
            host.wr_reg(8'hf0, 8'(p));
            cfg_exp[p] = 8'($urandom) & 8'h77;
            evr_exp[p] = 8'($urandom);
            host.wr_reg(8'hf1, cfg_exp[p]);
            host.wr_reg(8'hf2, evr_exp[p]);
            evr_exp[p] = evr_exp[p] & 8'h03;
        end
        for (int p = 0; p < 8; p++)
        begin
            host.wr_reg(8'hf0, 8'(p));
            rd_chk(8'hf1, cfg_exp[p], "pin cfg");
            rd_chk(8'hf2, evr_exp[p], "pin routing");
            chk("driver on", {7'h0, cfg_exp[p][0]}, {7'h0, pin_oe[p]});
            chk("pullup", {7'h0, cfg_exp[p][2]}, {7'h0, pullup_on[p]});
        end
        // Reserved port numbers
        host.wr_reg(8'hf0, 8'hff);
        rd_chk(8'hf0, 8'h77, "selector");
        rd_chk(8'hf1, 8'h00, "reserved port");
        host.wr_reg(8'hf1, 8'h00);
        host.wr_reg(8'hf0, 8'h07);
        rd_chk(8'hf1, cfg_exp[7], "port write drop");
        // Lock on pin 5 freezes its protected fields
        data_wr(8'h30, 8'h30);
        chk("data out", 8'h30, pin_out & 8'h30);
        host.wr_reg(8'hf0, 8'h05);
        v = 8'($urandom) | 8'h08;
        host.wr_reg(8'hf1, v);
        cfg_exp[5] = cfg_after(cfg_exp[5], v);
        repeat (3)
        begin
            v = 8'($urandom);
            host.wr_reg(8'hf1, v);
            cfg_exp[5] = cfg_after(cfg_exp[5], v);
            rd_chk(8'hf1, cfg_exp[5], "locked cfg");
        end
        host.wr_reg(8'hf2, ~evr_exp[5]);
        rd_chk(8'hf2, evr_exp[5], "locked routing");
        data_wr(8'h30, 8'h00);
        chk("locked data", 8'h20, pin_out & 8'h30);
        // Main-supply load on pin 2, then supply drop
        host.wr_reg(8'hf0, 8'h02);
        host.wr_reg(8'hf3, 8'hff);
        rd_chk(8'hf3, 8'h10, "load flag");
        host.wr_reg(8'hf1, 8'h05);
        @(posedge clk);
        main_supply_low <= 1'b1;
        for (int i = 0; i < 10 && input_on[2] !== 1'b0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk("low supply pin", 8'h00, {5'h0, input_on[2], pullup_on[2], pin_oe[2]});
        chk("unloaded pin", 8'h01, {7'h0, input_on[0]});
        @(posedge clk);
        main_supply_low <= 1'b0;
        // Main reset clears standard regs and loaded pins only
        pulse_rst(1'b1);
        rd_chk(8'h30, 8'h00, "main reset activate");
        host.wr_reg(8'h30, 8'h01);
        rd_chk(8'h71, 8'h03, "main reset type");
        host.wr_reg(8'hf0, 8'h02);
        rd_chk(8'hf1, 8'h44, "loaded pin cfg");
        rd_chk(8'hf3, 8'h10, "load flag kept");
        host.wr_reg(8'hf1, 8'h05);
        host.wr_reg(8'hf0, 8'h00);
        rd_chk(8'hf1, cfg_exp[0], "standby pin kept");
        // Standby reset clears unloaded pins, lock survives
        pulse_rst(1'b0);
        rd_chk(8'hf0, 8'h00, "selector standby");
        rd_chk(8'hf1, 8'h44, "standby pin cfg");
        host.wr_reg(8'hf0, 8'h05);
        rd_chk(8'hf1, 8'h4c, "lock survives");
        host.wr_reg(8'hf0, 8'h02);
        rd_chk(8'hf1, 8'h05, "loaded pin kept");
        // Events: pin 1 level high, pin 3 rising edge, pin 6 debounced level
        host.wr_reg(8'hf0, 8'h01);
        host.wr_reg(8'hf1, 8'h30);
        host.wr_reg(8'hf2, 8'h03);
        host.wr_reg(8'hf0, 8'h03);
        host.wr_reg(8'hf1, 8'h20);
        host.wr_reg(8'hf2, 8'h02);
        host.wr_reg(8'hf0, 8'h06);
        host.wr_reg(8'hf1, 8'h70);
        host.wr_reg(8'hf2, 8'h01);
        host.wr_reg(8'h30, 8'h00);
        host.wr_reg(8'hf0, 8'h01);
        rd_chk(8'hf1, 8'h00, "inactive cfg");
        chk("idle level", 8'h00, {7'h0, host_event[1]});
        @(posedge clk);
        pin_in <= 8'h4a;
        n = 8'h00;
        m = 8'h00;
        v = 8'h00;
        rd = 8'h00;
        repeat (12)
        begin
            @(posedge clk);
            n = n + {7'h0, mgmt_event[3]};
            m = m + {7'h0, host_event[3]};
            v = v + {7'h0, host_event[1]};
            rd = rd + {7'h0, host_event[6]};
        end
        chk("edge pulses", 8'h01, n);
        chk("unrouted host", 8'h00, m);
        chk("level events", 8'h03, {6'h0, mgmt_event[1], host_event[1]});
        chk("debounce delay", 8'h01, {7'h0, rd < v && rd != 8'h00});
        summarize();
    end
endmodule : tb_top
`default_nettype wire
